// ==== rtl/prd_core.sv ====
// PLL reference and feedback dividers with clock source select.
// Assumes pins sampled by a 25 MHz clk and a byte register port.
//
// Notes on behaviour
// (RL1) Reference divider is 14 bits, any ratio 1 to 16383.
// (RL2) Reference ratio zero divides by one.
// (RL3) Reference ratio: six upper bits at 0Bh, eight lower at 0Ch.
// (RL4) Divided reference goes to one detector input.
// (RL5) Feedback: 3-bit prescaler mode, 6-bit swallow, 13-bit main count.
// (RL6) Fixed modes 000, 001, 111 divide by 1, 2, 3.
// (RL7) Two-ratio modes 010..110: 2/3, 4/5, 8/9, 16/17, 32/33.
// (RL8) Fixed modes ignore swallow; main count may be bypassed.
// (RL9) Host keeps oscillator below 600, 1000 or 1600 MHz per mode.
// (RL10) Main bypass, count of one, only honoured in fixed modes.
// (RL11) Bit 6 of 0Ah set bypasses the main counter.
// (RL12) Host programs main count 3 to 8191 when not bypassed.
// (RL13) Main count resets to zero, an invalid setting.
// (RL14) Own reset bit for swallow/main; 09h bit 0 resets all three.
// (RL15) Two-ratio total is modulus times main plus swallow.
// (RL16) Fixed total is ratio times main, swallow ignored.
// (RL17) Mode mix reaches every total division down to one.
// (RL18) Only the oscillator feedback input feeds the feedback divider.
// (RL19) Writing zero to 45h bit 0 selects oscillator feedback source.
// (RL20) Out of reset the distribution source is the auxiliary input.
// (RL21) Host keeps divided reference below detector maximum.
// (RL22) Modulus plus one until swallow expires, then modulus to end.
// (RL23) One pulse per programmed count; reload on own input edge.
`timescale 1ns/100ps
`include "prd_defines.svh"

module prd_core
  import prd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data_q,
  // Clock pins
  input wire logic reference_input,
  input wire logic oscillator_feedback_input,
  input wire logic auxiliary_clock_input,
  // Detector inputs
  output logic det_ref_pulse_q,
  output logic det_fb_pulse_q,
  // Distribution source
  output logic dist_clock_q,
  output logic dist_src_aux_q
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Bit 0 reference, bit 1 oscillator, bit 2 auxiliary
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [1:0] prev_q;
  logic ref_edge;
  logic osc_edge;

  assign pin_raw = {auxiliary_clock_input, oscillator_feedback_input,
                    reference_input};

  // Two stages per pin before any logic looks at it
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // Previous level for rising edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 2'h0;
    end
    else
    begin
      prev_q <= sync2_q[1:0];
    end
  end

  // Rising edges; the auxiliary input never reaches the divider
  assign ref_edge = sync2_q[0] & ~prev_q[0];
  assign osc_edge = sync2_q[1] & ~prev_q[1]; // RL18

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [5:0] ref_hi_q;
  logic [5:0] ref_hi_d;
  logic [7:0] ref_lo_q;
  logic [7:0] ref_lo_d;
  logic [5:0] swl_q;
  logic [5:0] swl_d;
  logic [4:0] main_hi_q;
  logic [4:0] main_hi_d;
  logic [7:0] main_lo_q;
  logic [7:0] main_lo_d;
  prd_mode_t mode_q;
  prd_mode_t mode_d;
  logic bypass_q;
  logic bypass_d;
  logic shared_rst_q;
  logic shared_rst_d;
  logic cnt_rst_q;
  logic cnt_rst_d;
  logic src_aux_q;
  logic src_aux_d;
  logic [7:0] rd_data_d;
  logic [7:0] status;
  logic fb_running;
  logic main_invalid;

  // Status: running, invalid main setting, source
  assign status = {5'h00, src_aux_q, main_invalid, fb_running};

  // Register writes and read mux
  always_comb
  begin
    ref_hi_d = ref_hi_q;
    ref_lo_d = ref_lo_q;
    swl_d = swl_q;
    main_hi_d = main_hi_q;
    main_lo_d = main_lo_q;
    mode_d = mode_q;
    bypass_d = bypass_q;
    shared_rst_d = shared_rst_q;
    cnt_rst_d = cnt_rst_q;
    src_aux_d = src_aux_q;
    rd_data_d = 8'h00;
    if (wr_en)
    begin
      case (addr)
        `PRD_OFF_RESET:
        begin
          shared_rst_d = wr_data[`PRD_BIT_SHARED_RST]; // RL14
          cnt_rst_d = wr_data[`PRD_BIT_CNT_RST]; // RL14
        end
        `PRD_OFF_FBCTL:
        begin
          bypass_d = wr_data[`PRD_BIT_BYPASS]; // RL11
          mode_d = wr_data[`PRD_MODE_MSB:`PRD_MODE_LSB]; // RL5
        end
        `PRD_OFF_REF_HI: ref_hi_d = wr_data[5:0]; // RL3
        `PRD_OFF_REF_LO: ref_lo_d = wr_data; // RL3
        `PRD_OFF_SRC: src_aux_d = wr_data[`PRD_BIT_SRC]; // RL19
        `PRD_OFF_SWL: swl_d = wr_data[5:0]; // RL5
        `PRD_OFF_MAIN_HI: main_hi_d = wr_data[4:0]; // RL5
        `PRD_OFF_MAIN_LO: main_lo_d = wr_data; // RL5
        default: ;
      endcase
    end
    if (rd_en)
    begin
      case (addr)
        `PRD_OFF_RESET: rd_data_d = {6'h00, cnt_rst_q, shared_rst_q};
        `PRD_OFF_FBCTL: rd_data_d = {1'b0, bypass_q, 1'b0, mode_q, 2'h0};
        `PRD_OFF_REF_HI: rd_data_d = {2'h0, ref_hi_q};
        `PRD_OFF_REF_LO: rd_data_d = ref_lo_q;
        `PRD_OFF_SRC: rd_data_d = {7'h00, src_aux_q};
        `PRD_OFF_SWL: rd_data_d = {2'h0, swl_q};
        `PRD_OFF_MAIN_HI: rd_data_d = {3'h0, main_hi_q};
        `PRD_OFF_MAIN_LO: rd_data_d = main_lo_q;
        `PRD_OFF_STATUS: rd_data_d = status;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  // Register state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_hi_q <= 6'(`PRD_RST_REF >> 8);
      ref_lo_q <= 8'(`PRD_RST_REF);
      swl_q <= `PRD_RST_SWL;
      main_hi_q <= 5'(`PRD_RST_MAIN >> 8); // RL13
      main_lo_q <= 8'(`PRD_RST_MAIN); // RL13
      mode_q <= `PRD_RST_MODE;
      bypass_q <= 1'b0;
      shared_rst_q <= 1'b0;
      cnt_rst_q <= 1'b0;
      src_aux_q <= `PRD_RST_SRC; // RL20
      rd_data_q <= 8'h00;
    end
    else
    begin
      ref_hi_q <= ref_hi_d;
      ref_lo_q <= ref_lo_d;
      swl_q <= swl_d;
      main_hi_q <= main_hi_d;
      main_lo_q <= main_lo_d;
      mode_q <= mode_d;
      bypass_q <= bypass_d;
      shared_rst_q <= shared_rst_d;
      cnt_rst_q <= cnt_rst_d;
      src_aux_q <= src_aux_d;
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference divider

  // Divided reference drives the detector reference input
  prd_ref_divider u_ref_div
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(shared_rst_q), // RL14
    .in_edge(ref_edge),
    .ratio({ref_hi_q, ref_lo_q}), // RL3
    .out_pulse_q(det_ref_pulse_q) // RL4
  );

  ////////////////////////////////////////////////////////////////////////
  // Prescaler mode decode

  prd_kind_t kind;
  logic [5:0] modulus;
  logic [12:0] main_cnt;
  logic [12:0] main_eff;
  logic [5:0] swl_eff;

  // Modulus per mode code
  always_comb
  begin
    case (mode_q)
      `PRD_PM_FIX1: modulus = 6'h01; // RL6
      `PRD_PM_FIX2: modulus = 6'h02; // RL6
      `PRD_PM_FIX3: modulus = 6'h03; // RL6
      `PRD_PM_TWO2: modulus = 6'h02; // RL7
      `PRD_PM_TWO4: modulus = 6'h04; // RL7
      `PRD_PM_TWO8: modulus = 6'h08; // RL7
      `PRD_PM_TWO16: modulus = 6'h10; // RL7
      `PRD_PM_TWO32: modulus = 6'h20; // RL7
      default: modulus = 6'h01;
    endcase
  end

  // Effective counts; bypass only counts in fixed modes
  assign kind = (mode_q >= `PRD_PM_TWO2 && mode_q <= `PRD_PM_TWO32) ?
                PRD_KIND_TWO_RATIO : PRD_KIND_FIXED; // RL6 RL7
  assign main_cnt = {main_hi_q, main_lo_q};
  assign main_eff = (kind == PRD_KIND_FIXED && bypass_q) ?
                    13'h0001 : main_cnt; // RL10 RL8 RL17
  assign swl_eff = (kind == PRD_KIND_FIXED) ? 6'h00 : swl_q; // RL8 RL16
  assign main_invalid = (main_eff == 13'h0000); // RL13
  assign fb_running = ~main_invalid & ~shared_rst_q & ~cnt_rst_q;

  ////////////////////////////////////////////////////////////////////////
  // Feedback divider

  logic [5:0] presc_q;
  logic [5:0] presc_d;
  logic [5:0] swl_left_q;
  logic [5:0] swl_left_d;
  logic [12:0] main_left_q;
  logic [12:0] main_left_d;
  logic fb_pulse_d;
  logic [5:0] mod_now;

  // Prescaler, swallow and main counting on oscillator edges
  always_comb
  begin
    presc_d = presc_q;
    swl_left_d = swl_left_q;
    main_left_d = main_left_q;
    fb_pulse_d = 1'b0;
    mod_now = (swl_left_q != 6'h00) ?
              6'(modulus + 6'h01) : modulus; // RL22
    if (!fb_running)
    begin
      // Prescaler held cleared, swallow and main counters held loaded, while reset or main count invalid
      presc_d = 6'h00; // RL14
      swl_left_d = swl_eff;
      main_left_d = main_eff;
    end
    else if (osc_edge)
    begin
      if (presc_q >= 6'(mod_now - 6'h01))
      begin
        presc_d = 6'h00;
        if (swl_left_q != 6'h00)
        begin
          swl_left_d = 6'(swl_left_q - 6'h01); // RL22
        end
        if (main_left_q <= 13'h0001)
        begin
          // Both counters reload together with the pulse
          swl_left_d = swl_eff; // RL23
          main_left_d = main_eff; // RL23
          fb_pulse_d = 1'b1; // RL15 RL16
        end
        else
        begin
          main_left_d = 13'(main_left_q - 13'h0001);
        end
      end
      else
      begin
        presc_d = 6'(presc_q + 6'h01);
      end
    end
  end

  // Feedback divider state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_q <= 6'h00;
      swl_left_q <= `PRD_RST_SWL;
      main_left_q <= `PRD_RST_MAIN;
      det_fb_pulse_q <= 1'b0;
    end
    else
    begin
      presc_q <= presc_d;
      swl_left_q <= swl_left_d;
      main_left_q <= main_left_d;
      det_fb_pulse_q <= fb_pulse_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Distribution source select

  logic dist_clock_d;

  // Auxiliary when set, oscillator feedback when cleared
  assign dist_clock_d = src_aux_q ? sync2_q[2] : sync2_q[1]; // RL19

  // Registered source outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dist_clock_q <= 1'b0;
      dist_src_aux_q <= `PRD_RST_SRC; // RL20
    end
    else
    begin
      dist_clock_q <= dist_clock_d;
      dist_src_aux_q <= src_aux_q;
    end
  end

endmodule

// ==== rtl/prd_defines.svh ====
// Constants of the reference and feedback divider block.
// Assumes byte-wide registers on an 8-bit address port.
`ifndef PRD_DEFINES_SVH
`define PRD_DEFINES_SVH

// Register offsets
`define PRD_OFF_RESET 8'h09
`define PRD_OFF_FBCTL 8'h0A
`define PRD_OFF_REF_HI 8'h0B
`define PRD_OFF_REF_LO 8'h0C
`define PRD_OFF_SRC 8'h45
`define PRD_OFF_SWL 8'h60
`define PRD_OFF_MAIN_HI 8'h61
`define PRD_OFF_MAIN_LO 8'h62
`define PRD_OFF_STATUS 8'h63

// Field positions
`define PRD_BIT_SHARED_RST 0
`define PRD_BIT_CNT_RST 1
`define PRD_BIT_BYPASS 6
`define PRD_MODE_LSB 2
`define PRD_MODE_MSB 4
`define PRD_BIT_SRC 0

// Prescaler mode codes
`define PRD_PM_FIX1 3'h0
`define PRD_PM_FIX2 3'h1
`define PRD_PM_TWO2 3'h2
`define PRD_PM_TWO4 3'h3
`define PRD_PM_TWO8 3'h4
`define PRD_PM_TWO16 3'h5
`define PRD_PM_TWO32 3'h6
`define PRD_PM_FIX3 3'h7

// Reset values
`define PRD_RST_REF 14'h0001
`define PRD_RST_SWL 6'h00
`define PRD_RST_MAIN 13'h0000
`define PRD_RST_MODE 3'h0
`define PRD_RST_SRC 1'h1

`endif

// ==== rtl/prd_pkg.sv ====
// Types shared by the divider block.
// Assumes prd_defines.svh holds every number.
package prd_pkg;

  // Kind of prescaler division in force
  typedef enum logic {PRD_KIND_FIXED, PRD_KIND_TWO_RATIO} prd_kind_t;

  // Prescaler mode field
  typedef logic [2:0] prd_mode_t;

endpackage

// ==== rtl/prd_ref_divider.sv ====
// Reference divider: one pulse per programmed count of input edges.
// Assumes in_edge is a one-cycle pulse already synchronised to clk.
`timescale 1ns/100ps
`include "prd_defines.svh"

module prd_ref_divider
  import prd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic in_edge,
  input wire logic [13:0] ratio,
  // Divided output
  output logic out_pulse_q
);

  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic [13:0] last;
  logic out_pulse_d;

  // Next count; zero ratio counts as one
  always_comb
  begin
    last = (ratio == 14'h0000) ? 14'h0000 : 14'(ratio - 14'h0001); // RL2
    cnt_d = cnt_q;
    out_pulse_d = 1'b0;
    if (clear)
    begin
      cnt_d = 14'h0000; // RL14
    end
    else if (in_edge)
    begin
      if (cnt_q >= last)
      begin
        cnt_d = 14'h0000; // RL23
        out_pulse_d = 1'b1; // RL1
      end
      else
      begin
        cnt_d = 14'(cnt_q + 14'h0001);
      end
    end
  end

  // Count registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 14'h0000;
      out_pulse_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_pulse_q <= out_pulse_d;
    end
  end

endmodule

// ==== verification/prd_core_checker.sv ====
// Port checker for the divider block.
// Assumes a bind onto prd_core and a single clock domain.
`timescale 1ns/100ps

module prd_core_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data_q,
  // Clock pins
  input wire logic reference_input,
  input wire logic oscillator_feedback_input,
  input wire logic auxiliary_clock_input,
  // Outputs
  input wire logic det_ref_pulse_q,
  input wire logic det_fb_pulse_q,
  input wire logic dist_clock_q,
  input wire logic dist_src_aux_q
);
  logic [13:0] ratio_q, ratio_d;
  logic hold_q, hold_d;

  ////////////////////////////////////////////////////////////////////////
  // Shadow of reference ratio and shared reset bit
  always_comb
  begin
    ratio_d = ratio_q;
    hold_d = hold_q;
    if (wr_en && addr == 8'h0B)
      ratio_d[13:8] = wr_data[5:0];
    if (wr_en && addr == 8'h0C)
      ratio_d[7:0] = wr_data;
    if (wr_en && addr == 8'h09)
      hold_d = wr_data[0];
  end

  // Shadow registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ratio_q <= 14'h0001;
      hold_q <= 1'b0;
    end
    else
    begin
      ratio_q <= ratio_d;
      hold_q <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ref_one_shot_a: assert property (det_ref_pulse_q |=> !det_ref_pulse_q)
    else $error("reference pulse too long");
  fb_one_shot_a: assert property (det_fb_pulse_q |=> !det_fb_pulse_q)
    else $error("feedback pulse too long");
  ref_unity_a: assert property ($rose(reference_input) ##0
    (ratio_q <= 14'h0001 && !hold_q)[*5] |->
    det_ref_pulse_q || $past(det_ref_pulse_q)) else $error("ratio one");
  hold_idle_a: assert property (hold_q && $past(hold_q, 2) |->
    !det_ref_pulse_q && !det_fb_pulse_q) else $error("pulse in reset");
  src_write_a: assert property (wr_en && addr == 8'h45 |->
    ##2 dist_src_aux_q == $past(wr_data[0], 2)) else $error("source");
  aux_path_a: assert property (dist_src_aux_q |->
    dist_clock_q == $past(auxiliary_clock_input, 3)) else $error("aux path");
  osc_path_a: assert property (!dist_src_aux_q |->
    dist_clock_q == $past(oscillator_feedback_input, 3)) else $error("osc");
  ref_lo_read_a: assert property (rd_en && addr == 8'h0C |=>
    rd_data_q == ratio_q[7:0]) else $error("ratio low byte");
  ref_hi_read_a: assert property (rd_en && addr == 8'h0B |=>
    rd_data_q[5:0] == ratio_q[13:8]) else $error("ratio high byte");

  // Main scenarios reached
  cover property (det_fb_pulse_q);
  cover property (hold_q ##1 !hold_q);
  cover property (wr_en && addr == 8'h45 && !wr_data[0]);
endmodule

bind prd_core prd_core_checker chk (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data_q(rd_data_q), .reference_input(reference_input),
  .oscillator_feedback_input(oscillator_feedback_input),
  .auxiliary_clock_input(auxiliary_clock_input),
  .det_ref_pulse_q(det_ref_pulse_q), .det_fb_pulse_q(det_fb_pulse_q),
  .dist_clock_q(dist_clock_q), .dist_src_aux_q(dist_src_aux_q));

// ==== verification/prd_osc_model.sv ====
// Reference source, oscillator and auxiliary clock sources.
// Assumes pins are sampled by clk; each rests low while stopped.
`timescale 1ns/100ps

module prd_osc_model #(
  parameter int HALF = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Run enables: reference, oscillator, auxiliary
  input wire logic [2:0] run,
  // Clock pins in the same order
  output logic [2:0] pins
);
  logic [7:0] cnt [3];

  // Toggle each source every HALF cycles, two at the least
  always @(posedge clk or negedge rst_n)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!rst_n || !run[i])
      begin
        cnt[i] <= 8'h00;
        pins[i] <= 1'b0;
      end
      else if (cnt[i] >= 8'(HALF - 1) && cnt[i] >= 8'h01)
      begin
        cnt[i] <= 8'h00;
        pins[i] <= !pins[i];
      end
      else
        cnt[i] <= cnt[i] + 8'h01;
    end
  end
endmodule

// ==== verification/prd_core_tb.sv ====
// Self-checking bench for the divider block.
// Assumes prd_osc_model drives the pins with four-cycle periods.
`timescale 1ns/100ps

module prd_core_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [2:0] run = 3'h0;
  logic [2:0] pins;
  logic [7:0] rd_data_q;
  logic ref_p, fb_p, dclk, src_aux;
  int mismatches = 0;
  int compares = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock
  always #20 clk = ~clk;

  prd_osc_model #(.HALF(2)) far (.clk(clk), .rst_n(rst_n), .run(run),
    .pins(pins));
  prd_core dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_q(rd_data_q), .reference_input(pins[0]),
    .oscillator_feedback_input(pins[1]),
    .auxiliary_clock_input(pins[2]), .det_ref_pulse_q(ref_p),
    .det_fb_pulse_q(fb_p), .dist_clock_q(dclk),
    .dist_src_aux_q(src_aux));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    v = rd_data_q;
  endtask

  // Cycles up to the next pulse, bounded
  task automatic wait_p(input bit fb, output int c);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end
    while (!(fb ? fb_p : ref_p) && c < 40000);
  endtask

  // Period between settled pulses, four cycles per pin edge
  task automatic gap(input bit fb, input int n);
    int c;
    repeat (3) wait_p(fb, c);
    if (c != n * 4)
      chk(1'b0, "divider period");
    else
      chk(1'b1, "");
  endtask

  task automatic quiet(input bit r, input bit f, input int cyc);
    int k;
    k = 0;
    repeat (cyc)
    begin
      @(negedge clk);
      if ((r && ref_p !== 1'b0) || (f && fb_p !== 1'b0))
        k++;
    end
    chk(k == 0, "pulse while idle");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] v;
    logic [7:0] ra [6] = '{8'h0B, 8'h0C, 8'h45, 8'h0A, 8'h62, 8'h10};
    logic [7:0] rv [6] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    foreach (ra[i])
    begin
      rd(ra[i], v);
      chk(v === rv[i], "reset value");
    end
    chk(src_aux === 1'b1, "source after reset");
    quiet(1'b0, 1'b1, 200);
  endtask

  task automatic t_ref();
    logic [7:0] v;
    wr(8'h0C, 8'h00);
    gap(1'b0, 1);
    wr(8'h0C, 8'h03);
    gap(1'b0, 3);
    wr(8'h0B, 8'h01);
    wr(8'h0C, 8'h01);
    gap(1'b0, 257);
    rd(8'h0B, v);
    chk(v === 8'h01, "ratio high byte");
    wr(8'h0B, 8'h00);
  endtask

  // Mode, bypass, swallow, main count, total; main 3 up unbypassed
  task automatic t_fb();
    int md [12] = '{0, 1, 7, 0, 1, 7, 2, 2, 3, 4, 5, 6};
    int bp [12] = '{1, 1, 1, 0, 0, 0, 0, 1, 0, 0, 0, 0};
    int sw [12] = '{0, 0, 0, 0, 5, 0, 1, 1, 1, 2, 1, 1};
    int mn [12] = '{0, 0, 0, 3, 3, 4, 3, 3, 3, 3, 3, 3};
    int n [12] = '{1, 2, 3, 3, 6, 12, 7, 7, 13, 26, 49, 97};
    for (int i = 0; i < 12; i++)
    begin
      wr(8'h0A, 8'(bp[i] * 64 + md[i] * 4));
      wr(8'h60, 8'(sw[i]));
      wr(8'h61, 8'(mn[i] >> 8));
      wr(8'h62, 8'(mn[i]));
      gap(1'b1, n[i]);
    end
  endtask

  task automatic t_resets();
    wr(8'h0A, 8'h40);
    wr(8'h09, 8'h01);
    repeat (4) @(negedge clk);
    quiet(1'b1, 1'b1, 60);
    wr(8'h09, 8'h00);
    gap(1'b1, 1);
    wr(8'h09, 8'h02);
    repeat (4) @(negedge clk);
    quiet(1'b0, 1'b1, 60);
    gap(1'b0, 1);
    wr(8'h09, 8'h00);
    gap(1'b1, 1);
  endtask

  task automatic t_src();
    logic [7:0] v;
    int k;
    run <= 3'h5;
    wr(8'h45, 8'h00);
    repeat (2) @(negedge clk);
    chk(src_aux === 1'b0, "source select");
    rd(8'h45, v);
    chk(v === 8'h00, "source readback");
    k = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (dclk !== 1'b0)
        k++;
    end
    chk(k == 0, "aux leaks into oscillator path");
    wr(8'h45, 8'h01);
    repeat (2) @(negedge clk);
    chk(src_aux === 1'b1, "source back to aux");
    k = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (dclk === 1'b1)
        k++;
    end
    chk(k > 0, "aux clock missing at output");
    run <= 3'h7;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    run <= 3'h7;
    t_reset();
    t_ref();
    t_fb();
    t_resets();
    t_src();
    stop_test();
  end

  // Watchdog
  initial
  begin
    #1000000;
    mismatches++;
    stop_test();
  end
endmodule
